// ### hdl/glb_cfg_pkg.sv
// constants and carrier types for the global configuration register group
// Function
// - endian strap latched at reset into config bit 10, 1 means little endian
// - prom presence strap latched at reset into config bit 9
// - config bit 7 reads 1 in 8-bit host bus mode
// - config bit 6 reads 1 in 16-bit host bus mode
// - config bit 4 always reads 1, shared address and data bus
// - after reset with the prom presence strap set, the three address words load from prom starting at word 1
// - word 1 to low, word 2 to middle, word 3 to high register
// - software accesses touch only registers, never written back to the prom
// - each address word is a 16-bit read-write register, low word least significant
// - control bit 4 hands the prom pins to software via bits 3 to 0
// - write-only control bit 5 picks direction, 1 writes, 0 reads
// - control bit 3 reads the live prom data pin level
// - control bit 2 drives the prom data pin under software access
// - control bit 1 drives the prom clock pin
// - control bit 0 drives the prom select pin
// - self-test bit 15 reads 0 while running, 1 when done
// - self-test bit 12 reads 1 when transmit memory test completed
// - self-test bit 11 reads 1 when transmit memory test failed
// - self-test bits 10 to 8 report the failure count, zero when none
// - writing 1 to the start control starts the self-test, 0 stops it
package glb_cfg_pkg;
   localparam logic [8:0]  CFG_OFS       = 9'h108;
   localparam logic [8:0]  ADDR_LO_OFS   = 9'h110;
   localparam logic [8:0]  ADDR_MID_OFS  = 9'h112;
   localparam logic [8:0]  ADDR_HI_OFS   = 9'h114;
   localparam logic [8:0]  PROM_CTL_OFS  = 9'h122;
   localparam logic [8:0]  TEST_RES_OFS  = 9'h124;
   localparam logic [8:0]  TEST_CTL_OFS  = 9'h126;
   localparam int          CFG_ENDIAN_B  = 10;
   localparam int          CFG_PRESENT_B = 9;
   localparam int          CFG_W8_B      = 7;
   localparam int          CFG_W16_B     = 6;
   localparam int          CFG_SHARED_B  = 4;
   localparam int          PC_DIR_B      = 5;
   localparam int          PC_EN_B       = 4;
   localparam int          PC_DIN_B      = 3;
   localparam int          PC_DOUT_B     = 2;
   localparam int          PC_CLK_B      = 1;
   localparam int          PC_SEL_B      = 0;
   localparam int          TR_DONE_B     = 15;
   localparam int          TR_TXDONE_B   = 12;
   localparam int          TR_FAIL_B     = 11;
   localparam int          TR_CNT_LSB    = 8;
   localparam int          TC_START_B    = 3;
   localparam logic [15:0] ADDR_RST      = 16'h0000;
   localparam logic [1:0]  FIRST_WORD    = 2'h1;
   localparam logic [1:0]  LAST_WORD     = 2'h3;
   localparam logic [2:0]  READ_OPCODE   = 3'h6;
   localparam int          CLK_NS        = 10;
   localparam int          PROM_HALF_NS  = 500;
   localparam int          PROM_HALF_CYC = (PROM_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int          TEST_CYC      = 1024;
   typedef struct packed {
      logic sel;
      logic clk;
      logic dout;
      logic oe_n;
   } prom_pins_t;
   typedef struct packed {
      logic endian;
      logic present;
      logic w8;
   } straps_t;
endpackage

// ### hdl/global_config_eeprom_bist_regs.sv
// global configuration, host address, prom pin control and self-test registers
`timescale 1ns/1ps
module global_config_eeprom_bist_regs (
   input  wire  logic                    ref_clk,
   input  wire  logic                    rstn,
   input  wire  logic [8:0]              addr,
   input  wire  logic [15:0]             wr_data,
   input  wire  logic                    wr_en,
   input  wire  logic                    rd_en,
   output logic [15:0]                   rd_data,
   input  wire  glb_cfg_pkg::straps_t    strap_pins,
   input  wire  logic                    prom_data_in,
   output glb_cfg_pkg::prom_pins_t       prom_pins,
   input  wire  logic                    tx_mem_mismatch,
   output logic                          tx_mem_test_run
);
   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_CMD  = 3'b001,
      L_DATA = 3'b011,
      L_GAP  = 3'b010,
      L_DONE = 3'b110
   } ld_state_t;

   glb_cfg_pkg::straps_t     strap_reg, strap_next;
   ld_state_t                ld_reg, ld_next;
   logic [6:0]               div_reg, div_next;
   logic                     sk_reg, sk_next;
   logic                     lsel_reg, lsel_next;
   logic [3:0]               bit_reg, bit_next;
   logic [1:0]               word_reg, word_next;
   logic [8:0]               cmd_reg, cmd_next;
   logic [15:0]              dat_reg, dat_next;
   logic [15:0]              mac_reg [3];
   logic [15:0]              mac_next [3];
   logic                     tick;
   logic                     load_pulse;
   logic                     en_reg, en_next;
   logic                     dir_reg, dir_next;
   logic                     swd_reg, swd_next;
   logic                     swc_reg, swc_next;
   logic                     sws_reg, sws_next;
   glb_cfg_pkg::prom_pins_t  pins_reg, pins_next;
   logic                     run_reg, run_next;
   logic                     done_reg, done_next;
   logic                     fail_reg, fail_next;
   logic [2:0]               fcnt_reg, fcnt_next;
   logic [9:0]               tcnt_reg, tcnt_next;
   logic                     start_reg, start_next;
   logic [15:0]              rd_reg, rd_next;

   // straps follow the pins while reset is held, frozen at release
   always_comb begin
      strap_next = rstn ? strap_reg : strap_pins;
   end

   always_ff @(posedge ref_clk) begin
      strap_reg <= strap_next;
   end

   // clock divider for the loader, free running keeps it simple
   assign tick = (div_reg == 7'(glb_cfg_pkg::PROM_HALF_CYC - 1));

   // reset loader: read command, 16 data bits, repeat for three words
   always_comb begin
      ld_next    = ld_reg;
      div_next   = tick ? 7'h00 : div_reg + 7'h01;
      sk_next    = sk_reg;
      lsel_next  = lsel_reg;
      bit_next   = bit_reg;
      word_next  = word_reg;
      cmd_next   = cmd_reg;
      dat_next   = dat_reg;
      load_pulse = 1'b0;
      case (ld_reg)
         L_IDLE: begin
            if (strap_reg.present) begin
               ld_next   = L_CMD;
               lsel_next = 1'b1;
               word_next = glb_cfg_pkg::FIRST_WORD;
               cmd_next  = {glb_cfg_pkg::READ_OPCODE, 4'h0, glb_cfg_pkg::FIRST_WORD};
               bit_next  = 4'h0;
            end else begin
               ld_next = L_DONE; // software writes the address
            end
         end
         L_CMD: begin
            if (tick) begin
               sk_next = ~sk_reg;
               if (sk_reg) begin
                  if (bit_reg == 4'h8) begin
                     ld_next  = L_DATA;
                     bit_next = 4'h0;
                  end else begin
                     bit_next = bit_reg + 4'h1;
                     cmd_next = {cmd_reg[7:0], 1'b0};
                  end
               end
            end
         end
         L_DATA: begin
            if (tick) begin
               sk_next = ~sk_reg;
               if (!sk_reg) begin
                  dat_next = {dat_reg[14:0], prom_data_in}; // sample on rising clock
               end else if (bit_reg == 4'hF) begin
                  load_pulse = 1'b1;
                  lsel_next  = 1'b0;
                  ld_next    = L_GAP;
               end else begin
                  bit_next = bit_reg + 4'h1;
               end
            end
         end
         L_GAP: begin
            if (tick) begin
               if (word_reg == glb_cfg_pkg::LAST_WORD) begin
                  ld_next = L_DONE;
               end else begin
                  word_next = word_reg + 2'h1;
                  cmd_next  = {glb_cfg_pkg::READ_OPCODE, 4'h0, word_reg + 2'h1};
                  bit_next  = 4'h0;
                  lsel_next = 1'b1;
                  ld_next   = L_CMD;
               end
            end
         end
         L_DONE: begin
            ld_next = L_DONE; // one load per reset, never writes back
         end
         default: begin
            ld_next = L_DONE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ld_reg   <= L_IDLE;
         div_reg  <= 7'h00;
         sk_reg   <= 1'b0;
         lsel_reg <= 1'b0;
         bit_reg  <= 4'h0;
         word_reg <= 2'h0;
         cmd_reg  <= 9'h000;
         dat_reg  <= 16'h0000;
      end else begin
         ld_reg   <= ld_next;
         div_reg  <= div_next;
         sk_reg   <= sk_next;
         lsel_reg <= lsel_next;
         bit_reg  <= bit_next;
         word_reg <= word_next;
         cmd_reg  <= cmd_next;
         dat_reg  <= dat_next;
      end
   end

   // address words: loader fills them, software may overwrite later
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         mac_next[i] = mac_reg[i];
         if (wr_en && addr == glb_cfg_pkg::ADDR_LO_OFS + 9'(2 * i)) begin
            mac_next[i] = wr_data;
         end
         if (load_pulse && word_reg == 2'(i + 1)) begin
            mac_next[i] = dat_reg;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 3; i++) begin
         mac_reg[i] <= rstn ? mac_next[i] : glb_cfg_pkg::ADDR_RST;
      end
   end

   // software pin control bits and the pin mux
   always_comb begin
      en_next  = en_reg;
      dir_next = dir_reg;
      swd_next = swd_reg;
      swc_next = swc_reg;
      sws_next = sws_reg;
      if (wr_en && addr == glb_cfg_pkg::PROM_CTL_OFS) begin
         en_next  = wr_data[glb_cfg_pkg::PC_EN_B];
         dir_next = wr_data[glb_cfg_pkg::PC_DIR_B];
         swd_next = wr_data[glb_cfg_pkg::PC_DOUT_B];
         swc_next = wr_data[glb_cfg_pkg::PC_CLK_B];
         sws_next = wr_data[glb_cfg_pkg::PC_SEL_B];
      end
      if (en_reg) begin
         pins_next.sel  = sws_reg;
         pins_next.clk  = swc_reg;
         pins_next.dout = swd_reg;
         pins_next.oe_n = ~dir_reg;
      end else begin
         // loader owns pins; data is driven only while the command shifts
         pins_next.sel  = lsel_reg;
         pins_next.clk  = sk_reg;
         // dout parks low once the command is out, so no stale bit sits on the pin
         pins_next.dout = (ld_reg == L_CMD) ? cmd_reg[8] : 1'b0;
         pins_next.oe_n = (ld_reg != L_CMD);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         en_reg   <= 1'b0;
         dir_reg  <= 1'b0;
         swd_reg  <= 1'b0;
         swc_reg  <= 1'b0;
         sws_reg  <= 1'b0;
         pins_reg <= '{sel: 1'b0, clk: 1'b0, dout: 1'b0, oe_n: 1'b1};
      end else begin
         en_reg   <= en_next;
         dir_reg  <= dir_next;
         swd_reg  <= swd_next;
         swc_reg  <= swc_next;
         sws_reg  <= sws_next;
         pins_reg <= pins_next;
      end
   end

   // transmit memory self-test sequencer, starts itself after reset
   always_comb begin
      start_next = start_reg;
      run_next   = run_reg;
      done_next  = done_reg;
      fail_next  = fail_reg;
      fcnt_next  = fcnt_reg;
      tcnt_next  = tcnt_reg;
      if (run_reg) begin
         tcnt_next = tcnt_reg + 10'h001;
         if (tx_mem_mismatch) begin
            fail_next = 1'b1;
            fcnt_next = (fcnt_reg == 3'h7) ? fcnt_reg : fcnt_reg + 3'h1;
         end
         if (tcnt_reg == 10'(glb_cfg_pkg::TEST_CYC - 1)) begin
            run_next  = 1'b0;
            done_next = 1'b1;
         end
      end
      if (wr_en && addr == glb_cfg_pkg::TEST_CTL_OFS) begin
         start_next = wr_data[glb_cfg_pkg::TC_START_B];
         run_next   = wr_data[glb_cfg_pkg::TC_START_B];
         if (wr_data[glb_cfg_pkg::TC_START_B]) begin
            done_next = 1'b0;
            fail_next = 1'b0;
            fcnt_next = 3'h0;
            tcnt_next = 10'h000;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         start_reg <= 1'b0;
         run_reg   <= 1'b1;
         done_reg  <= 1'b0;
         fail_reg  <= 1'b0;
         fcnt_reg  <= 3'h0;
         tcnt_reg  <= 10'h000;
      end else begin
         start_reg <= start_next;
         run_reg   <= run_next;
         done_reg  <= done_next;
         fail_reg  <= fail_next;
         fcnt_reg  <= fcnt_next;
         tcnt_reg  <= tcnt_next;
      end
   end

   // read mux; data stands only in the cycle after the strobe
   always_comb begin
      rd_next = 16'h0000;
      if (rd_en) begin
         case (addr)
            glb_cfg_pkg::CFG_OFS: begin
               rd_next[glb_cfg_pkg::CFG_ENDIAN_B]  = strap_reg.endian;
               rd_next[glb_cfg_pkg::CFG_PRESENT_B] = strap_reg.present;
               rd_next[glb_cfg_pkg::CFG_W8_B]      = strap_reg.w8;
               rd_next[glb_cfg_pkg::CFG_W16_B]     = ~strap_reg.w8;
               rd_next[glb_cfg_pkg::CFG_SHARED_B]  = 1'b1;
            end
            glb_cfg_pkg::ADDR_LO_OFS:  rd_next = mac_reg[0];
            glb_cfg_pkg::ADDR_MID_OFS: rd_next = mac_reg[1];
            glb_cfg_pkg::ADDR_HI_OFS:  rd_next = mac_reg[2];
            glb_cfg_pkg::PROM_CTL_OFS: begin
               // direction bit is write only and reads back as zero
               rd_next[glb_cfg_pkg::PC_EN_B]   = en_reg;
               rd_next[glb_cfg_pkg::PC_DIN_B]  = prom_data_in;
               rd_next[glb_cfg_pkg::PC_DOUT_B] = swd_reg;
               rd_next[glb_cfg_pkg::PC_CLK_B]  = swc_reg;
               rd_next[glb_cfg_pkg::PC_SEL_B]  = sws_reg;
            end
            glb_cfg_pkg::TEST_RES_OFS: begin
               rd_next[glb_cfg_pkg::TR_DONE_B]   = done_reg;
               rd_next[glb_cfg_pkg::TR_TXDONE_B] = done_reg;
               rd_next[glb_cfg_pkg::TR_FAIL_B]   = fail_reg;
               rd_next[glb_cfg_pkg::TR_CNT_LSB +: 3] = fcnt_reg;
            end
            glb_cfg_pkg::TEST_CTL_OFS: rd_next[glb_cfg_pkg::TC_START_B] = start_reg;
            default: rd_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      rd_reg <= rstn ? rd_next : 16'h0000;
   end

   assign rd_data         = rd_reg;
   assign prom_pins       = pins_reg;
   assign tx_mem_test_run = run_reg;

   // checks
   a_cfg_read: assert property (@(posedge ref_clk) disable iff (!rstn)
      rd_en && addr == glb_cfg_pkg::CFG_OFS |=> rd_data[10:9] == {strap_reg.endian,
      strap_reg.present} && rd_data[4]) else $error("config read wrong");
   a_width_pair: assert property (@(posedge ref_clk) disable iff (!rstn)
      rd_en && addr == glb_cfg_pkg::CFG_OFS |=> rd_data[7] != rd_data[6])
      else $error("width bits not exclusive");
   a_load_word: assert property (@(posedge ref_clk) disable iff (!rstn)
      load_pulse && !wr_en |=> mac_reg[word_reg - 2'h1] == $past(dat_reg))
      else $error("address word not loaded");
   a_sw_write: assert property (@(posedge ref_clk) disable iff (!rstn)
      wr_en && addr == glb_cfg_pkg::ADDR_HI_OFS && !load_pulse |=> mac_reg[2] == $past(wr_data))
      else $error("high word write lost");
   a_sw_pins: assert property (@(posedge ref_clk) disable iff (!rstn)
      en_reg |=> prom_pins.sel == $past(sws_reg) && prom_pins.clk == $past(swc_reg))
      else $error("software pins not driven");
   a_ld_pins: assert property (@(posedge ref_clk) disable iff (!rstn)
      !en_reg |=> prom_pins.sel == $past(lsel_reg)) else $error("loader lost select pin");
   a_dir_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
      en_reg && !dir_reg |=> prom_pins.oe_n) else $error("drove data in read direction");
   a_test_done: assert property (@(posedge ref_clk) disable iff (!rstn)
      run_reg ##1 !run_reg && !$past(wr_en) |-> done_reg) else $error("test end without done");
   a_fail_cnt: assert property (@(posedge ref_clk) disable iff (!rstn)
      done_reg && !fail_reg |-> fcnt_reg == 3'h0) else $error("count without failure");
   a_din_live: assert property (@(posedge ref_clk) disable iff (!rstn)
      rd_en && addr == glb_cfg_pkg::PROM_CTL_OFS |=> rd_data[3] == $past(prom_data_in))
      else $error("data pin not reflected");
   // self-test control and status
   a_test_start: assert property (@(posedge ref_clk) disable iff (!rstn)
      wr_en && addr == glb_cfg_pkg::TEST_CTL_OFS && wr_data[glb_cfg_pkg::TC_START_B]
      |=> run_reg && !done_reg && !fail_reg) else $error("start write did not restart test");
   a_test_stop: assert property (@(posedge ref_clk) disable iff (!rstn)
      wr_en && addr == glb_cfg_pkg::TEST_CTL_OFS && !wr_data[glb_cfg_pkg::TC_START_B]
      |=> !run_reg) else $error("stop write did not halt test");
   a_busy_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
      run_reg |-> !done_reg) else $error("done shown while test runs");
   // prom pin ownership while the loader holds the pins, and the loader skip without a prom
   a_cmd_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
      !en_reg && ld_reg == L_CMD |=> !prom_pins.oe_n) else $error("command not driven");
   a_idle_dout: assert property (@(posedge ref_clk) disable iff (!rstn)
      !en_reg && ld_reg != L_CMD |=> prom_pins.oe_n && !prom_pins.dout)
      else $error("loader drove data outside command");
   a_no_prom: assert property (@(posedge ref_clk) disable iff (!rstn)
      ld_reg == L_IDLE && !strap_reg.present |=> ld_reg == L_DONE)
      else $error("loader ran without a prom");
   // read data must not linger past its one cycle
   a_read_once: assert property (@(posedge ref_clk) disable iff (!rstn)
      rd_en ##1 !rd_en |=> rd_data == 16'h0000) else $error("read data held too long");
   c_test_stop: cover property (@(posedge ref_clk) disable iff (!rstn)
      run_reg && wr_en && addr == glb_cfg_pkg::TEST_CTL_OFS
      && !wr_data[glb_cfg_pkg::TC_START_B]);
   c_no_prom: cover property (@(posedge ref_clk) disable iff (!rstn)
      ld_reg == L_IDLE && !strap_reg.present);
   c_load_done: cover property (@(posedge ref_clk) disable iff (!rstn)
      ld_reg == L_GAP && word_reg == glb_cfg_pkg::LAST_WORD);
   c_sw_access: cover property (@(posedge ref_clk) disable iff (!rstn) en_reg && dir_reg);
   c_test_fail: cover property (@(posedge ref_clk) disable iff (!rstn) done_reg && fail_reg);
endmodule // global_config_eeprom_bist_regs

// ### testbench/prom_model.sv
// serial prom model that answers the reset-time loader's read frames
`timescale 1ns/1ps
module prom_model (
   input  wire logic sel,
   input  wire logic sclk,
   input  wire logic sdi,
   output logic      q
);
   logic [15:0] mem [0:63];
   logic [8:0]  cmd;
   int          cnt;
   int          frames;
   int          bad_cmds;

   initial begin
      q = 1'b0;
      cmd = 9'h000;
      cnt = 0;
      frames = 0;
      bad_cmds = 0;
   end

   // a new frame clears the bit count
   always @(posedge sel) begin
      cnt = 0;
      frames++;
   end

   // released line flips so a stale bit never passes for fresh data
   always @(negedge sel) begin
      q = ~q;
   end

   // command bits taken on rising clock, msb first; only the read opcode is legal
   always @(posedge sclk) begin
      if (sel) begin
         if (cnt < 9) cmd = {cmd[7:0], sdi};
         if (cnt == 8 && cmd[8:6] != 3'h6) bad_cmds++;
         cnt++;
      end
   end

   // data launched on falling clock so it is settled at the next rising edge
   always @(negedge sclk) begin
      if (sel && cnt >= 9 && cnt < 25) q = mem[cmd[5:0]][24 - cnt];
   end
endmodule // prom_model

// ### testbench/test_global_config_eeprom_bist_regs.sv
// self-checking bench for the global configuration register group
`timescale 1ns/1ps
module test_global_config_eeprom_bist_regs;
   logic                    ref_clk;
   logic                    rstn;
   logic [8:0]              addr;
   logic [15:0]             wr_data;
   logic                    wr_en;
   logic                    rd_en;
   logic [15:0]             rd_data;
   glb_cfg_pkg::straps_t    strap_pins;
   glb_cfg_pkg::prom_pins_t prom_pins;
   logic                    tx_mem_mismatch;
   logic                    tx_mem_test_run;
   logic                    prom_q;
   logic                    pin_level;
   logic [31:0]             seed;
   logic [15:0]             got;
   logic [15:0]             cfg_exp;
   int                      words [3];
   int                      f;
   int                      num_errors;
   int                      checks_done;

   // wire level: the device drives the data pin only while its enable is low
   assign pin_level = prom_pins.oe_n ? prom_q : prom_pins.dout;

   global_config_eeprom_bist_regs dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .strap_pins(strap_pins), .prom_data_in(pin_level), .prom_pins(prom_pins),
      .tx_mem_mismatch(tx_mem_mismatch), .tx_mem_test_run(tx_mem_test_run));
   prom_model prom (.sel(prom_pins.sel), .sclk(prom_pins.clk), .sdi(prom_pins.dout),
      .q(prom_q));

   // free-running 100 MHz clock
   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic rnd(output logic [15:0] v);
      repeat (16) seed = lfsr(seed);
      v = seed[15:0];
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // strobes change just after an edge; one idle edge keeps a strobe from two values in one step
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      @(posedge ref_clk);
   endtask

   // read data stands only in the cycle after the strobe, taken at the edge ending it
   task automatic rd(input logic [8:0] a, output logic [15:0] d);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      @(posedge ref_clk);
      d = rd_data;
   endtask

   task automatic do_reset(input logic present);
      logic [15:0] r;
      rnd(r);
      strap_pins <= '{r[0], present, r[1]};
      rstn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      cfg_exp = {5'h00, r[0], present, 1'b0, r[1], ~r[1], 2'b01, 4'h0};
      rd(glb_cfg_pkg::CFG_OFS, got);
      chk(got, cfg_exp);
   endtask

   // pulses land while the test runs; count saturates at 7
   task automatic self_test(input int n);
      rd(glb_cfg_pkg::TEST_RES_OFS, got);
      chk(got & 16'h8000, 16'h0000);
      repeat (n) begin
         tx_mem_mismatch <= 1'b1;
         @(posedge ref_clk);
         tx_mem_mismatch <= 1'b0;
         @(posedge ref_clk);
      end
      for (int i = 0; i < 1100 && tx_mem_test_run !== 1'b0; i++) @(posedge ref_clk);
      rd(glb_cfg_pkg::TEST_RES_OFS, got);
      chk(got, 16'(32'h9000 | ((n > 0) << 11) | (((n > 7) ? 7 : n) << 8)));
      $display("self-test with %0d faults done", n);
   endtask

   // software writes then reads back all three address words
   task automatic addr_rw();
      logic [15:0] r;
      f = prom.frames;
      for (int w = 0; w < 3; w++) begin
         rnd(r);
         words[w] = r;
         wr(glb_cfg_pkg::ADDR_LO_OFS + 9'(2 * w), r);
      end
      for (int w = 0; w < 3; w++) begin
         rd(glb_cfg_pkg::ADDR_LO_OFS + 9'(2 * w), got);
         chk(got, 16'(words[w]));
      end
      chk(16'(prom.frames), 16'(f));
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // watchdog sized well above the loader and four self-test runs
   initial begin
      repeat (40000) @(posedge ref_clk);
      num_errors++;
      give_verdict();
   end

   initial begin
      seed = 32'h9DA4;
      num_errors = 0;
      checks_done = 0;
      rstn = 1'b0;
      addr = 9'h000;
      wr_data = 16'h0000;
      wr_en = 1'b0;
      rd_en = 1'b0;
      tx_mem_mismatch = 1'b0;
      strap_pins = '0;
      for (int w = 0; w < 3; w++) begin
         rnd(got);
         words[w] = got;
         prom.mem[w + 1] = got;
      end
      do_reset(1'b1);
      self_test(2);
      for (int i = 0; i < 9000 && !(prom.frames == 3 && !prom_pins.sel); i++)
         @(posedge ref_clk);
      repeat (4) @(posedge ref_clk);
      chk(16'(prom.bad_cmds), 16'h0000);
      for (int w = 0; w < 3; w++) begin
         rd(glb_cfg_pkg::ADDR_LO_OFS + 9'(2 * w), got);
         chk(got, 16'(words[w]));
      end
      addr_rw();
      $display("address load and rewrite done");
      // software pin control, both directions
      for (int v = 0; v < 16; v++) begin
         wr(glb_cfg_pkg::PROM_CTL_OFS, {10'h000, v[3], 1'b1, 1'b0, v[2], v[1], v[0]});
         @(posedge ref_clk);
         chk({12'h000, prom_pins}, {12'h000, v[0], v[1], v[2], ~v[3]});
         rd(glb_cfg_pkg::PROM_CTL_OFS, got);
         chk(got, {10'h000, 2'b01, v[3] ? v[2] : prom_q, v[2], v[1], v[0]});
      end
      wr(glb_cfg_pkg::PROM_CTL_OFS, 16'h0007);
      repeat (2) @(posedge ref_clk);
      chk({12'h000, prom_pins}, 16'h0001);
      $display("pin control done");
      // restart, then a stop in mid-run
      wr(glb_cfg_pkg::TEST_CTL_OFS, 16'h0008);
      self_test(9);
      wr(glb_cfg_pkg::TEST_CTL_OFS, 16'h0008);
      self_test(0);
      wr(glb_cfg_pkg::TEST_CTL_OFS, 16'h0008);
      wr(glb_cfg_pkg::TEST_CTL_OFS, 16'h0000);
      @(posedge ref_clk);
      chk({15'h0000, tx_mem_test_run}, 16'h0000);
      // unmapped and read-only places ignore writes
      wr(9'h116, 16'hFFFF);
      rd(9'h116, got);
      chk(got, 16'h0000);
      wr(glb_cfg_pkg::CFG_OFS, 16'hFFFF);
      rd(glb_cfg_pkg::CFG_OFS, got);
      chk(got, cfg_exp);
      $display("refused accesses done");
      // host resets after the self-test, this time without a prom
      f = prom.frames;
      do_reset(1'b0);
      repeat (200) @(posedge ref_clk);
      chk(16'(prom.frames), 16'(f));
      for (int w = 0; w < 3; w++) begin
         rd(glb_cfg_pkg::ADDR_LO_OFS + 9'(2 * w), got);
         chk(got, glb_cfg_pkg::ADDR_RST);
      end
      addr_rw();
      $display("no-prom reset done");
      give_verdict();
   end
endmodule // test_global_config_eeprom_bist_regs
